//--- tmr_consts.svh
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses on the Avalon-MM slave).
// ****************************************************************
`define TMR_OFS_MODE      5'h00
`define TMR_OFS_CAPCTL    5'h04
`define TMR_OFS_OUTCTL    5'h08
`define TMR_OFS_PRESC     5'h0C
`define TMR_OFS_COUNTER   5'h10
`define TMR_OFS_CAPCMP0   5'h14
`define TMR_OFS_CAPCMP1   5'h18

// ****************************************************************
// Widths, field positions and field values.
// ****************************************************************
`define TMR_CNT_W         16
`define TMR_MODE_EDGE     2'h2
`define TMR_SRC_EDGE      2'h3
`define TMR_EDGE_FALL     2'h0
`define TMR_EDGE_RISE     2'h1
`define TMR_EDGE_BOTH     2'h3
`define TMR_BIT_EDGETOG   1
`define TMR_BIT_CAP0      0
`define TMR_BIT_REVPH     1
`define TMR_BIT_CAP1      2
`define TMR_BIT_OUTEN     0
`define TMR_BIT_TOG0      1
`define TMR_BIT_TOG1      2
`define TMR_CNT_MAX       16'hFFFF
`define TMR_CNT_ZERO      16'h0000

// ****************************************************************
// Reset values.
// ****************************************************************
`define TMR_RST_MODE      4'h0
`define TMR_RST_CAPCTL    3'h0
`define TMR_RST_OUTCTL    3'h0
`define TMR_RST_PRESC     8'h00
`define TMR_RST_CAPCMP    16'h0000
`define TMR_RST_RDATA     32'h0000_0000

`endif

//--- tmr_pkg.sv
`include "tmr_consts.svh"

package tmr_pkg;

    // Filtered edge events of one input pin.
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_evt_t;

    // State of one edge filter.
    typedef struct packed {
        logic [1:0] smp;
        logic       lvl;
        edge_evt_t  evt;
    } filt_state_t;

    // State of the timer core and its bus slave.
    typedef struct packed {
        logic [3:0]                modeCtl;
        logic [2:0]                capCtl;
        logic [2:0]                outCtl;
        logic [7:0]                prescSel;
        logic [1:0]                divCnt;
        logic [`TMR_CNT_W-1:0]     counter;
        logic                      cntMoved;
        logic [`TMR_CNT_W-1:0]     capcmpZero;
        logic [`TMR_CNT_W-1:0]     capcmpOne;
        logic                      outLevel;
        logic                      pinOut;
        logic                      irqZero;
        logic                      irqOne;
        logic                      ack;
        logic [31:0]               rdData;
    } tmr_state_t;

endpackage : tmr_pkg

//--- edge_filter.sv
module edge_filter (
    input  wire logic              sys_clk,   // System clock.
    input  wire logic              rstSyncN,  // Synchronised reset, active low.
    input  wire logic              pinIn,     // Raw pin level.
    output tmr_pkg::edge_evt_t     evt        // One-cycle edge pulses.
);
    import tmr_pkg::*;

    filt_state_t st_r;
    filt_state_t st_nxt;

    // A new level is accepted only once seen on two samples in a row.
    always_comb begin
        st_nxt          = st_r;
        st_nxt.smp      = {st_r.smp[0], pinIn};
        st_nxt.evt.rise = 1'b0;
        st_nxt.evt.fall = 1'b0;
        if (st_r.smp[1] == st_r.smp[0] && st_r.smp[0] != st_r.lvl) begin
            st_nxt.lvl      = st_r.smp[0];
            st_nxt.evt.rise = st_r.smp[0];
            st_nxt.evt.fall = ~st_r.smp[0];
        end
    end

    // State register.
    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign evt = st_r.evt;

endmodule : edge_filter

//--- edge_clear_capcmp.sv
// How it works
// - Mode select bits equal to binary 10 enable the edge clear-and-restart mode.
// - Without a primary edge the counter wraps past its maximum and keeps counting.
// - A compare match raises that register's interrupt and leaves the counter alone.
// - Both capturing: secondary edge or opposite primary phase loads register zero.
// - A primary valid edge loads register one, raises irq one, clears counter.
// - Edge toggle clear: output flips only on compare matches.
// - Edge toggle set: output also flips on each primary valid edge.
// - Counter equal to register zero raises irq zero and may flip the output.
// - Capture one with edge toggle: capture, irq, clear and flip in one event.
// - Reverse phase: the selected primary edge clears, the opposite edge captures into zero.
// - Reverse-phase captures into register zero raise no interrupt.
// - Secondary valid edges still raise irq zero in reverse-phase capture.
// - Output flips on clearing edge and on register one compare match.
// - Both-edge primary selection captures, clears and flips on every edge.
// - The timer output is unavailable while secondary edge detection is used.
// - Reverse phase with a secondary edge raises irq zero without capturing.
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`include "tmr_consts.svh"

module edge_clear_capcmp #(
    parameter int CNT_W = 16                     // Counter width.
) (
    input  wire logic              sys_clk,            // System clock, 40 MHz.
    input  wire logic              arst_n,             // Asynchronous reset, active low.
    input  wire logic [4:0]        avs_address,        // Byte address.
    input  wire logic              avs_read,           // Read request.
    input  wire logic              avs_write,          // Write request.
    input  wire logic [31:0]       avs_writedata,      // Write data.
    input  wire logic [3:0]        avs_byteenable,     // Byte enables.
    output logic [31:0]            avs_readdata,       // Read data.
    output logic                   avs_waitrequest,    // Stall until answered.
    input  wire logic              edgeInputPrimary,   // Clear and capture trigger.
    input  wire logic              edgeInputSecondary, // Register zero capture trigger.
    output logic                   timerOutputPin,     // Timer output level.
    output logic                   irqZero,            // Interrupt zero pulse.
    output logic                   irqOne              // Interrupt one pulse.
);
    import tmr_pkg::*;

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************
    if (CNT_W != `TMR_CNT_W) begin : g_bad_width
        $error("Counter width must be 16.");
    end

    // ****************************************************************
    // Functions.
    // ****************************************************************

    // Returns whether an event matches an edge selection.
    function automatic logic edgeHit(input logic [1:0] sel, input edge_evt_t e);
        logic hit;
        hit = 1'b0;
        case (sel)
            `TMR_EDGE_FALL: hit = e.fall;
            `TMR_EDGE_RISE: hit = e.rise;
            `TMR_EDGE_BOTH: hit = e.rise | e.fall;
            default:        hit = 1'b0;
        endcase
        return hit;
    endfunction : edgeHit

    // Merges the low two byte lanes of a write into a 16-bit field.
    function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
        logic [15:0] v;
        v = old;
        if (be[0]) begin
            v[7:0] = wd[7:0];
        end
        if (be[1]) begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction : laneMerge

    // ****************************************************************
    // Reset release.
    // ****************************************************************
    logic [1:0]  rstPipe_r;
    logic        rstSyncN;

    // Two flops release the reset in step with the clock.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe_r <= 2'h0;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe_r[1];

    // ****************************************************************
    // Edge detection.
    // ****************************************************************
    edge_evt_t   primEvtRaw;
    edge_evt_t   secEvtRaw;

    edge_filter u_prim (
        .sys_clk  (sys_clk),
        .rstSyncN (rstSyncN),
        .pinIn    (edgeInputPrimary),
        .evt      (primEvtRaw)
    );

    edge_filter u_sec (
        .sys_clk  (sys_clk),
        .rstSyncN (rstSyncN),
        .pinIn    (edgeInputSecondary),
        .evt      (secEvtRaw)
    );

    // ****************************************************************
    // Decoded controls and events.
    // ****************************************************************
    tmr_state_t  st_r;
    tmr_state_t  st_nxt;
    logic        modeOn;
    logic        srcIsEdge;
    logic        cap0Mode;
    logic        cap1Mode;
    logic        revPhase;
    logic        edgeTog;
    logic        secUsed;
    logic        tick;
    logic        primEdge;
    logic        primRev;
    logic        secEdge;
    logic        matchZero;
    logic        matchOne;
    logic        togEvt;
    logic        busGo;
    logic        busDone;

    // Control fields as the timer logic sees them.
    assign modeOn    = st_r.modeCtl[3:2] == `TMR_MODE_EDGE;
    assign srcIsEdge = st_r.prescSel[1:0] == `TMR_SRC_EDGE;
    assign cap0Mode  = st_r.capCtl[`TMR_BIT_CAP0];
    assign cap1Mode  = st_r.capCtl[`TMR_BIT_CAP1];
    assign revPhase  = st_r.capCtl[`TMR_BIT_REVPH];
    assign edgeTog   = st_r.modeCtl[`TMR_BIT_EDGETOG];
    assign secUsed   = cap0Mode && !revPhase;

    // Count tick: every clock, every second or every fourth clock.
    assign tick = (st_r.prescSel[1:0] == 2'h0)
               || (st_r.prescSel[1:0] == 2'h1 && st_r.divCnt[0])
               || (st_r.prescSel[1:0] == 2'h2 && st_r.divCnt == 2'h3);

    // Valid edges; both-edge selection has no opposite phase.
    assign primEdge = modeOn && edgeHit(st_r.prescSel[5:4], primEvtRaw);
    assign primRev  = modeOn
                   && ((st_r.prescSel[5:4] == `TMR_EDGE_RISE && primEvtRaw.fall)
                   ||  (st_r.prescSel[5:4] == `TMR_EDGE_FALL && primEvtRaw.rise));
    assign secEdge  = modeOn && edgeHit(st_r.prescSel[7:6], secEvtRaw);

    // A match fires once for each new counter value that equals the register.
    assign matchZero = modeOn && !cap0Mode && st_r.cntMoved
                    && st_r.counter == st_r.capcmpZero;
    assign matchOne  = modeOn && !cap1Mode && st_r.cntMoved
                    && st_r.counter == st_r.capcmpOne;

    // Output flips on enabled matches and, with edge toggle, on clearing edges.
    assign togEvt = (matchZero && st_r.outCtl[`TMR_BIT_TOG0])
                 || (matchOne  && st_r.outCtl[`TMR_BIT_TOG1])
                 || (primEdge  && edgeTog);

    assign busGo = (avs_read || avs_write) && !st_r.ack;
    // A write lands at the edge that ends its transfer, where waitrequest is low.
    assign busDone = (avs_read || avs_write) && st_r.ack;

    // ****************************************************************
    // Next state.
    // ****************************************************************

    // Bus access first, so that hardware captures below win over writes.
    always_comb begin
        st_nxt          = st_r;
        st_nxt.irqZero  = 1'b0;
        st_nxt.irqOne   = 1'b0;
        st_nxt.divCnt   = st_r.divCnt + 2'h1;
        st_nxt.ack      = busGo;
        st_nxt.cntMoved = 1'b0;
        if (busDone && avs_write) begin
            if (avs_address == `TMR_OFS_MODE) begin
                st_nxt.modeCtl = 4'(laneMerge({12'h000, st_r.modeCtl},
                                              avs_writedata, avs_byteenable));
            end else if (avs_address == `TMR_OFS_CAPCTL) begin
                st_nxt.capCtl = 3'(laneMerge({13'h0000, st_r.capCtl},
                                             avs_writedata, avs_byteenable));
            end else if (avs_address == `TMR_OFS_OUTCTL) begin
                st_nxt.outCtl = 3'(laneMerge({13'h0000, st_r.outCtl},
                                             avs_writedata, avs_byteenable));
            end else if (avs_address == `TMR_OFS_PRESC) begin
                st_nxt.prescSel = 8'(laneMerge({8'h00, st_r.prescSel},
                                               avs_writedata, avs_byteenable));
            end else if (avs_address == `TMR_OFS_CAPCMP0) begin
                st_nxt.capcmpZero = laneMerge(st_r.capcmpZero, avs_writedata,
                                              avs_byteenable);
            end else if (avs_address == `TMR_OFS_CAPCMP1) begin
                st_nxt.capcmpOne = laneMerge(st_r.capcmpOne, avs_writedata,
                                             avs_byteenable);
            end
        end
        if (busGo && avs_read) begin
            if (avs_address == `TMR_OFS_MODE) begin
                st_nxt.rdData = {28'h000_0000, st_r.modeCtl};
            end else if (avs_address == `TMR_OFS_CAPCTL) begin
                st_nxt.rdData = {29'h0000_0000, st_r.capCtl};
            end else if (avs_address == `TMR_OFS_OUTCTL) begin
                st_nxt.rdData = {29'h0000_0000, st_r.outCtl};
            end else if (avs_address == `TMR_OFS_PRESC) begin
                st_nxt.rdData = {24'h00_0000, st_r.prescSel};
            end else if (avs_address == `TMR_OFS_COUNTER) begin
                st_nxt.rdData = {16'h0000, st_r.counter};
            end else if (avs_address == `TMR_OFS_CAPCMP0) begin
                st_nxt.rdData = {16'h0000, st_r.capcmpZero};
            end else if (avs_address == `TMR_OFS_CAPCMP1) begin
                st_nxt.rdData = {16'h0000, st_r.capcmpOne};
            end else begin
                st_nxt.rdData = `TMR_RST_RDATA;
            end
        end

        // Counter: held clear when off or on the edge source, cleared by the primary edge, else counting.
        if (!modeOn || srcIsEdge) begin
            st_nxt.counter = `TMR_CNT_ZERO;
        end else if (primEdge) begin
            st_nxt.counter  = `TMR_CNT_ZERO;
            st_nxt.cntMoved = 1'b1;
        end else if (tick) begin
            st_nxt.counter  = st_r.counter + 16'h0001;
            st_nxt.cntMoved = 1'b1;
        end

        // Register one captures on the primary edge, before the clear.
        if (cap1Mode && primEdge) begin
            st_nxt.capcmpOne = st_r.counter;
        end
        if (primEdge && cap1Mode) begin
            st_nxt.irqOne = 1'b1;
        end
        if (matchOne) begin
            st_nxt.irqOne = 1'b1;
        end

        // Register zero: secondary edge or opposite primary phase.
        if (cap0Mode && !revPhase && secEdge) begin
            st_nxt.capcmpZero = st_r.counter;
        end
        if (cap0Mode && revPhase && primRev) begin
            st_nxt.capcmpZero = st_r.counter;
        end
        if ((cap0Mode && secEdge) || matchZero) begin
            st_nxt.irqZero = 1'b1;
        end

        // Output level and the pin, which is blocked while the secondary is used.
        if (togEvt) begin
            st_nxt.outLevel = ~st_r.outLevel;
        end
        st_nxt.pinOut = st_nxt.outLevel && st_nxt.outCtl[`TMR_BIT_OUTEN]
                     && !(st_nxt.capCtl[`TMR_BIT_CAP0]
                     && !st_nxt.capCtl[`TMR_BIT_REVPH]);
    end

    // State register.
    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            st_r            <= '0;
            st_r.modeCtl    <= `TMR_RST_MODE;
            st_r.capCtl     <= `TMR_RST_CAPCTL;
            st_r.outCtl     <= `TMR_RST_OUTCTL;
            st_r.prescSel   <= `TMR_RST_PRESC;
            st_r.capcmpZero <= `TMR_RST_CAPCMP;
            st_r.capcmpOne  <= `TMR_RST_CAPCMP;
            st_r.rdData     <= `TMR_RST_RDATA;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign avs_readdata    = st_r.rdData;
    assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
    assign timerOutputPin  = st_r.pinOut;
    assign irqZero         = st_r.irqZero;
    assign irqOne          = st_r.irqOne;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstSyncN);

    a_mode_gate_off: assert property (!modeOn |=> st_r.counter == 16'h0000)
        else $error("Counter moved outside the edge clear mode.");
    a_edge_src_hold: assert property (srcIsEdge |=> st_r.counter == 16'h0000)
        else $error("Counter moved with edge count source.");
    a_roll_over: assert property (modeOn && !srcIsEdge && tick && !primEdge
        && st_r.counter == 16'hFFFF |=> st_r.counter == 16'h0000 && st_r.cntMoved)
        else $error("Counter did not wrap.");
    a_count_step: assert property (modeOn && !srcIsEdge && tick && !primEdge
        |=> st_r.counter == $past(st_r.counter) + 16'h0001)
        else $error("Counter did not step by one.");
    a_cap_one_clr: assert property (primEdge && cap1Mode && !srcIsEdge
        |=> st_r.capcmpOne == $past(st_r.counter) && irqOne && st_r.counter == 16'h0000)
        else $error("Primary edge did not capture and clear.");
    a_match_no_clr: assert property (matchZero && !primEdge && tick && !srcIsEdge
        |=> irqZero && st_r.counter == $past(st_r.counter) + 16'h0001)
        else $error("Compare match cleared counter or gave no interrupt.");
    a_toggle_match: assert property (matchZero && st_r.outCtl[1] && !matchOne
        && !(primEdge && edgeTog) |=> st_r.outLevel != $past(st_r.outLevel))
        else $error("Output did not flip on match zero.");
    a_edge_tog_off: assert property (!edgeTog && !matchZero && !matchOne
        |=> st_r.outLevel == $past(st_r.outLevel))
        else $error("Output flipped without a match.");
    a_edge_tog_on: assert property (edgeTog && primEdge && !matchZero && !matchOne
        |=> st_r.outLevel != $past(st_r.outLevel))
        else $error("Output did not flip on primary edge.");
    a_rev_no_irq: assert property (cap0Mode && revPhase && primRev && !secEdge
        && !matchZero |=> !irqZero && st_r.capcmpZero == $past(st_r.counter))
        else $error("Reverse phase capture misbehaved.");
    a_sec_irq_only: assert property (cap0Mode && revPhase && secEdge && !primRev && !avs_write
        |=> irqZero && st_r.capcmpZero == $past(st_r.capcmpZero))
        else $error("Secondary edge captured or gave no interrupt.");
    a_pin_blocked: assert property (secUsed |-> !timerOutputPin)
        else $error("Timer output active while secondary edge in use.");

    c_edge_clear: cover property (primEdge && cap1Mode ##1 st_r.counter == 16'h0000);
    c_wrap: cover property (modeOn && st_r.counter == 16'hFFFF ##1 st_r.counter == 16'h0000);
    c_rev_cap: cover property (cap0Mode && revPhase && primRev);
    c_sec_cap: cover property (cap0Mode && !revPhase && secEdge);

endmodule : edge_clear_capcmp

//--- edge_partner.sv
// ****************************************************************
// Model of the sources that drive the two edge inputs.
// ****************************************************************
module edge_partner (
    input  wire logic sys_clk, // System clock.
    input  wire logic wantP,   // Primary level asked for by the bench.
    input  wire logic wantS,   // Secondary level asked for by the bench.
    output logic      edgeP,   // Primary edge line.
    output logic      edgeS    // Secondary edge line.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both lines start low so the design never sees an unknown level.
    initial {edgeP, edgeS} = 2'b00;
    // The lines move just after a rising edge, like a source synchronous to sys_clk.
    always @(posedge sys_clk) begin
        edgeP <= wantP;
        edgeS <= wantS;
    end
endmodule : edge_partner

//--- testbench.sv
`include "tmr_consts.svh"
// ****************************************************************
// Self-checking bench of the edge clear-and-restart timer mode.
// ****************************************************************
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        arst_n = 1'b0, avsRd = 1'b0, avsWr = 1'b0, wantP = 1'b0, wantS = 1'b0;
    logic        sys_clk, stall, edgeP, edgeS, pinOut, irq0, irq1, pinPrev = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [15:0] rd, rd2, k;
    int          num_errors, checks, cyc, nIrq0, nIrq1, nFlip, hold;
    logic [3:0]  modeTab[3] = '{4'h8, 4'hA, 4'hA};
    logic [7:0]  presTab[3] = '{8'h10, 8'h10, 8'h30};
    logic [15:0] irqTab[3]  = '{16'h0001, 16'h0001, 16'h0002};
    logic [15:0] flipTab[3] = '{16'h0000, 16'h0001, 16'h0002};
    edge_clear_capcmp #(.CNT_W(16)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(adr),
        .avs_read(avsRd), .avs_write(avsWr), .avs_writedata(wdat), .avs_byteenable(4'hF),
        .avs_readdata(rdat), .avs_waitrequest(stall), .edgeInputPrimary(edgeP),
        .edgeInputSecondary(edgeS), .timerOutputPin(pinOut), .irqZero(irq0), .irqOne(irq1));
    edge_partner far (.sys_clk(sys_clk), .wantP(wantP), .wantS(wantS), .edgeP(edgeP), .edgeS(edgeS));
    // The 40 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Counts interrupt pulses and output flips, and cuts a hang short.
    always @(posedge sys_clk) begin
        cyc++;
        nIrq0 += int'(irq0 === 1'b1);
        nIrq1 += int'(irq1 === 1'b1);
        nFlip += int'(pinOut !== pinPrev);
        pinPrev = pinOut;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    // One bus transfer, held until waitrequest is seen low; read data lands in rd.
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        adr   <= a;
        wdat  <= {16'h0000, d};
        avsWr <= w;
        avsRd <= !w;
        do @(posedge sys_clk); while (stall !== 1'b0);
        rd = rdat[15:0];
        avsWr <= 1'b0;
        avsRd <= 1'b0;
    endtask : bus
    // Writes the four control registers, the mode last.
    task automatic cfg(input logic [3:0] m, input logic [2:0] c, input logic [2:0] o,
                       input logic [7:0] p);
        bus(1'b1, `TMR_OFS_PRESC, {8'h00, p});
        bus(1'b1, `TMR_OFS_CAPCTL, {13'h0000, c});
        bus(1'b1, `TMR_OFS_OUTCTL, {13'h0000, o});
        bus(1'b1, `TMR_OFS_MODE, {12'h000, m});
    endtask : cfg
    // Asks the partner for new line levels and lets the effect settle.
    task automatic pin(input logic p, input logic s);
        wantP <= p;
        wantS <= s;
        hold = 10 + $urandom_range(3);
        repeat (hold) @(posedge sys_clk);
    endtask : pin
    // Compares one value and counts the result.
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Clears the event counts.
    task automatic zero_counts();
        nIrq0 = 0;
        nIrq1 = 0;
        nFlip = 0;
    endtask : zero_counts
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    // Main sequence.
    initial begin
        void'($urandom(96));
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus(1'b0, `TMR_OFS_MODE, 16'h0000);
        chk("mode after reset", 16'h0000, rd);
        bus(1'b0, 5'h1C, 16'h0000);
        chk("unmapped read", 16'h0000, rd);
        cfg(4'h0, 3'h0, 3'h0, 8'h10);
        bus(1'b0, `TMR_OFS_COUNTER, 16'h0000);
        chk("counter other mode", 16'h0000, rd);
        cfg(4'h8, 3'h0, 3'h0, 8'h13);
        bus(1'b0, `TMR_OFS_COUNTER, 16'h0000);
        chk("counter edge source", 16'h0000, rd);
        cfg(4'h8, 3'h0, 3'h0, 8'h10);
        bus(1'b0, `TMR_OFS_COUNTER, 16'h0000);
        rd2 = rd;
        bus(1'b0, `TMR_OFS_COUNTER, 16'h0000);
        chk("counter step", rd2 + 16'h0003, rd);
        $display("test setup done");
        for (int i = 0; i < 3; i++) begin
            cfg(modeTab[i], 3'h4, 3'h1, presTab[i]);
            bus(1'b0, `TMR_OFS_COUNTER, 16'h0000);
            rd2 = rd;
            zero_counts();
            pin(1'b1, 1'b0);
            bus(1'b0, `TMR_OFS_CAPCMP1, 16'h0000);
            chk("capture one", 16'h0001, {15'h0000, rd > rd2});
            pin(1'b0, 1'b0);
            bus(1'b0, `TMR_OFS_COUNTER, 16'h0000);
            chk("counter cleared", 16'h0001, {15'h0000, rd < 16'h0028});
            chk("irq one pulses", irqTab[i], 16'(nIrq1));
            chk("output flips", flipTab[i], 16'(nFlip));
        end
        $display("test capture done");
        k = 16'h0004 + 16'($urandom_range(30));
        cfg(4'h0, 3'h0, 3'h7, 8'h10);
        bus(1'b1, `TMR_OFS_CAPCMP0, k);
        bus(1'b1, `TMR_OFS_CAPCMP1, k + 16'h0005);
        bus(1'b1, `TMR_OFS_MODE, 16'h0008);
        zero_counts();
        repeat (60) @(posedge sys_clk);
        chk("match irq zero", 16'h0001, 16'(nIrq0));
        chk("match irq one", 16'h0001, 16'(nIrq1));
        chk("match flip", 16'h0002, 16'(nFlip));
        bus(1'b0, `TMR_OFS_COUNTER, 16'h0000);
        chk("counter kept", 16'h0001, {15'h0000, rd > k});
        $display("test compare done");
        cfg(4'h8, 3'h3, 3'h0, 8'h10);
        zero_counts();
        pin(1'b1, 1'b0);
        bus(1'b0, `TMR_OFS_COUNTER, 16'h0000);
        rd2 = rd;
        pin(1'b0, 1'b0);
        bus(1'b0, `TMR_OFS_CAPCMP0, 16'h0000);
        chk("reverse capture", 16'h0001, {15'h0000, rd > rd2 && rd < 16'h0028});
        chk("reverse irq silent", 16'h0000, 16'(nIrq0));
        rd2 = rd;
        pin(1'b0, 1'b1);
        pin(1'b0, 1'b0);
        chk("secondary irq zero", 16'h0001, 16'(nIrq0));
        bus(1'b0, `TMR_OFS_CAPCMP0, 16'h0000);
        chk("secondary no capture", rd2, rd);
        cfg(4'hA, 3'h1, 3'h1, 8'h10);
        pin(1'b1, 1'b0);
        chk("output unavailable", 16'h0000, {15'h0000, pinOut});
        zero_counts();
        pin(1'b1, 1'b1);
        pin(1'b1, 1'b0);
        chk("sec capture irq", 16'h0001, 16'(nIrq0));
        bus(1'b0, `TMR_OFS_CAPCMP0, 16'h0000);
        chk("sec capture", 16'h0001, {15'h0000, rd > 16'h0000 && rd < 16'h0028});
        $display("test reverse done");
        // Pulse width: falling edge clears, rising edge captures into zero.
        cfg(4'h8, 3'h7, 3'h0, 8'h00);
        zero_counts();
        pin(1'b0, 1'b0);
        pin(1'b1, 1'b0);
        k = 16'(hold);
        pin(1'b0, 1'b0);
        bus(1'b0, `TMR_OFS_CAPCMP0, 16'h0000);
        rd2 = rd;
        bus(1'b0, `TMR_OFS_CAPCMP1, 16'h0000);
        chk("high width", k, rd - rd2);
        chk("width irq one", 16'h0002, 16'(nIrq1));
        chk("width irq zero", 16'h0000, 16'(nIrq0));
        $display("test width done");
        final_report();
    end
endmodule : testbench
